// File: scs_pkg.sv
// package of constants and types for the subroutine call stack
package scs_pkg;
	localparam int ADDR_W      = 12;
	localparam int DATA_W      = 8;
	localparam int STACK_DEPTH = 30;
	localparam int PTR_W       = 5;
	localparam int HI_NIB_W    = 4;
	localparam logic [ADDR_W-1:0] PC_RESET  = 12'h000;
	localparam logic [PTR_W-1:0]  PTR_RESET = 5'h00;
	localparam logic [PTR_W-1:0]  PTR_FULL  = 5'h1e;

	typedef enum logic [3:0] {
		SCS_OP_NONE   = 4'h0,
		SCS_OP_STEP   = 4'h1,
		SCS_OP_CALL   = 4'h2,
		SCS_OP_CALLC  = 4'h3,
		SCS_OP_CALLI  = 4'h4,
		SCS_OP_RET    = 4'h5,
		SCS_OP_RETC   = 4'h6,
		SCS_OP_IRQ    = 4'h7,
		SCS_OP_IRET   = 4'h8
	} scs_op_t;

	typedef enum logic [1:0] {
		SCS_COND_Z  = 2'h0,
		SCS_COND_NZ = 2'h1,
		SCS_COND_C  = 2'h2,
		SCS_COND_NC = 2'h3
	} scs_cond_t;
endpackage

// File: scs_call_stack.sv
// program counter and return stack sequencing of the core
`timescale 1ns/100ps
`default_nettype none

//==============================================================
// call stack
//==============================================================
// Overview of operation
// - call pushes pc, loads immediate target
// - return pops entry, adds one, loads pc
// - conditional call taken only if condition holds
// - untaken conditional call just increments pc
// - conditional call never alters zero, carry flags
// - indirect target is high nibble plus low byte
// - upper nibble ignored, registers left untouched
// - indirect call pushes its own location
// - thirty levels, interrupt entry uses one
// - entries leave in reverse order of entry
// - overflow on call or interrupt resets core
// - underflow on any exit resets core
// - untaken conditional return just increments pc
module scs_call_stack #(
	parameter int DEPTH = scs_pkg::STACK_DEPTH
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	input  wire scs_pkg::scs_op_t           op_i,
	input  wire scs_pkg::scs_cond_t         cond_i,
	input  wire logic                       zero_flag_i,
	input  wire logic                       carry_flag_i,
	input  wire logic [scs_pkg::ADDR_W-1:0] target_i,
	input  wire logic [scs_pkg::DATA_W-1:0] high_target_register_i,
	input  wire logic [scs_pkg::DATA_W-1:0] low_target_register_i,
	input  wire logic [scs_pkg::ADDR_W-1:0] irq_vector_i,
	output logic      [scs_pkg::ADDR_W-1:0] pc_o,
	output logic      [scs_pkg::PTR_W-1:0]  depth_o,
	output logic                            internal_reset_o
);
	import scs_pkg::*;

	// full mark follows the depth parameter, so a build up to 31 deep keeps its limit
	localparam logic [PTR_W-1:0] SP_FULL = PTR_W'(DEPTH);

	logic [ADDR_W-1:0] stack_mem [DEPTH];
	logic [ADDR_W-1:0] pc;
	logic [PTR_W-1:0]  sp;
	logic              int_rst;
	logic              cond_ok;
	logic              do_push;
	logic              do_pop;
	logic              is_exit;
	logic              fault;
	logic              overflow;
	logic              underflow;
	logic [ADDR_W-1:0] next_pc;
	logic [ADDR_W-1:0] top_entry;
	logic [ADDR_W-1:0] indirect_target;

	//==============================================================
	// condition and target decode
	//==============================================================
	// flags are only read here, never written, so no path alters them
	always_comb begin
		case (cond_i)
			SCS_COND_Z:  cond_ok = zero_flag_i;
			SCS_COND_NZ: cond_ok = !zero_flag_i;
			SCS_COND_C:  cond_ok = carry_flag_i;
			SCS_COND_NC: cond_ok = !carry_flag_i;
			default:     cond_ok = 1'b0;
		endcase
	end

	// upper nibble of the high register is dropped on purpose
	assign indirect_target = {high_target_register_i[HI_NIB_W-1:0], low_target_register_i};

	// an empty stack would index below slot zero, so it reads the reset location
	assign top_entry = (sp != PTR_RESET) ? stack_mem[sp - 5'h01] : PC_RESET;

	always_comb begin
		do_push = 1'b0;
		do_pop  = 1'b0;
		is_exit = 1'b0;
		next_pc = pc;
		case (op_i)
			SCS_OP_STEP: begin
				next_pc = pc + 12'h001;
			end
			SCS_OP_CALL: begin
				do_push = 1'b1;
				next_pc = target_i;
			end
			SCS_OP_CALLC: begin
				do_push = cond_ok;
				next_pc = cond_ok ? target_i : pc + 12'h001;
			end
			SCS_OP_CALLI: begin
				do_push = 1'b1;
				next_pc = indirect_target;
			end
			SCS_OP_IRQ: begin
				do_push = 1'b1;
				next_pc = irq_vector_i;
			end
			SCS_OP_RET, SCS_OP_IRET: begin
				do_pop  = 1'b1;
				is_exit = 1'b1;
				next_pc = top_entry + 12'h001;
			end
			SCS_OP_RETC: begin
				do_pop  = cond_ok;
				is_exit = cond_ok;
				next_pc = cond_ok ? top_entry + 12'h001 : pc + 12'h001;
			end
			default: begin
				next_pc = pc;
			end
		endcase
	end

	// a fault is caught before any state moves, so a bad push never lands
	// a push onto a full stack and an exit from an empty one share one path
	assign overflow  = do_push && (sp == SP_FULL);
	assign underflow = is_exit && (sp == PTR_RESET);
	assign fault     = overflow || underflow;

	//==============================================================
	// state
	//==============================================================
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || int_rst) begin
			pc <= PC_RESET;
		end else if (!fault) begin
			pc <= next_pc;
		end else begin
			pc <= PC_RESET;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || int_rst || fault) begin
			sp <= PTR_RESET;
		end else if (do_push) begin
			sp <= sp + 5'h01;
		end else if (do_pop) begin
			sp <= sp - 5'h01;
		end
	end

	// memory has no reset; an empty pointer makes its contents unreachable
	always_ff @(posedge clk_i) begin
		if (rst_n_i && !int_rst && !fault && do_push) begin
			stack_mem[sp] <= pc;
		end
	end

	// one cycle pulse so the rest of the core clears alongside the stack
	// a fault seen during the pulse is dropped, the core is already clearing
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			int_rst <= 1'b0;
		end else begin
			int_rst <= fault && !int_rst;
		end
	end

	assign pc_o             = pc;
	assign depth_o          = sp;
	assign internal_reset_o = int_rst;

	//==============================================================
	// checks
	//==============================================================
	chk_call_loads_target: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_CALL && !int_rst && !fault) |=> (pc == $past(target_i) && sp == $past(sp) + 5'h01))
		else $error("call did not load target and push");

	chk_ret_increments: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_RET && !int_rst && !fault) |=> (pc == $past(top_entry) + 12'h001))
		else $error("return did not load popped entry plus one");

	chk_callc_untaken: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_CALLC && !cond_ok && !int_rst) |=> (pc == $past(pc) + 12'h001 && sp == $past(sp)))
		else $error("untaken conditional call changed stack");

	chk_callc_taken: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_CALLC && cond_ok && !int_rst && !fault) |=> (pc == $past(target_i)))
		else $error("taken conditional call missed target");

	chk_indirect_target: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_CALLI && !int_rst && !fault) |=>
		(pc == {$past(high_target_register_i[3:0]), $past(low_target_register_i)}))
		else $error("indirect call target wrong");

	chk_indirect_push: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_CALLI && !int_rst && !fault) ##1 (op_i == SCS_OP_RET && !int_rst)
		|=> (pc == $past(pc, 2) + 12'h001))
		else $error("indirect call return location wrong");

	chk_retc_untaken: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_RETC && !cond_ok && !int_rst) |=> (pc == $past(pc) + 12'h001 && sp == $past(sp)))
		else $error("untaken conditional return popped");

	chk_overflow_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(do_push && sp == SP_FULL && !int_rst) |=> (int_rst && pc == PC_RESET && sp == PTR_RESET))
		else $error("overflow did not reset core");

	chk_underflow_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(is_exit && sp == PTR_RESET && !int_rst) |=> (int_rst && pc == PC_RESET) ##1 !int_rst)
		else $error("underflow did not reset core");

	chk_depth_limit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sp <= SP_FULL)
		else $error("stack depth above thirty");

	chk_irq_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_IRQ && !int_rst && !fault) |=> (sp == $past(sp) + 5'h01 && pc == $past(irq_vector_i)))
		else $error("interrupt entry did not take a level");

	chk_reset_state: assert property (@(posedge clk_i)
		(!rst_n_i || int_rst) |=> (pc == PC_RESET && sp == PTR_RESET))
		else $error("reset state wrong");

	//==============================================================
	// condition checks, decoded straight from the flag pins
	//==============================================================
	// these bypass the shared condition decode, so a slip there shows up
	// one check per taken variant keeps a failure pointing at its own condition
	chk_callc_zero_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_CALLC && cond_i == SCS_COND_Z && zero_flag_i && !int_rst && !fault)
		|=> (pc == $past(target_i) && sp == $past(sp) + 5'h01))
		else $error("call on zero set missed target");

	chk_callc_when_nonequal: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_CALLC && cond_i == SCS_COND_NZ && !zero_flag_i && !int_rst && !fault)
		|=> (pc == $past(target_i) && sp == $past(sp) + 5'h01))
		else $error("call on zero clear missed target");

	chk_callc_carry_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_CALLC && cond_i == SCS_COND_C && carry_flag_i && !int_rst && !fault)
		|=> (pc == $past(target_i) && sp == $past(sp) + 5'h01))
		else $error("call on carry set missed target");

	chk_callc_carry_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_CALLC && cond_i == SCS_COND_NC && !carry_flag_i && !int_rst && !fault)
		|=> (pc == $past(target_i) && sp == $past(sp) + 5'h01))
		else $error("call on carry clear missed target");

	chk_callc_skip_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_CALLC && !int_rst &&
		 ((cond_i == SCS_COND_Z && !zero_flag_i) || (cond_i == SCS_COND_NZ && zero_flag_i) ||
		  (cond_i == SCS_COND_C && !carry_flag_i) || (cond_i == SCS_COND_NC && carry_flag_i)))
		|=> (pc == $past(pc) + 12'h001 && sp == $past(sp)))
		else $error("untaken conditional call did not just step");

	//==============================================================
	// stack movement and fault checks
	//==============================================================
	// a push must land in the slot the pointer named before it moved
	chk_push_stores: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(do_push && !fault && !int_rst) |=> (stack_mem[$past(sp)] == $past(pc)))
		else $error("push stored a wrong location");

	chk_ret_pops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(is_exit && !fault && !int_rst) |=> (sp == $past(sp) - 5'h01))
		else $error("exit did not remove one level");

	// an interrupt exit pops exactly like a return
	chk_iret_increments: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_IRET && !int_rst && !fault)
		|=> (pc == $past(top_entry) + 12'h001))
		else $error("interrupt exit did not resume after entry");

	chk_retc_taken: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_RETC && cond_ok && !int_rst && !fault) |=> (pc == $past(top_entry) + 12'h001))
		else $error("taken conditional return missed entry");

	chk_retc_underflow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_RETC && cond_ok && sp == PTR_RESET && !int_rst) |=> (int_rst && pc == PC_RESET))
		else $error("conditional return underflow not caught");

	// the pulse lasts one cycle and only a fault can raise it
	chk_pulse_single: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		int_rst |=> !int_rst)
		else $error("internal reset pulse too long");

	chk_pulse_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(int_rst) |-> $past(fault))
		else $error("internal reset without a fault");

	chk_untaken_no_fault: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		((op_i == SCS_OP_CALLC || op_i == SCS_OP_RETC) && !cond_ok) |-> !fault)
		else $error("untaken conditional op raised a fault");

	//==============================================================
	// covers
	//==============================================================
	cov_nested_call: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		(op_i == SCS_OP_CALL && !fault) ##1 (op_i == SCS_OP_CALL && !fault) ##1 (op_i == SCS_OP_RET));
	cov_overflow: cover property (@(posedge clk_i) disable iff (!rst_n_i) (do_push && sp == SP_FULL));
	cov_underflow: cover property (@(posedge clk_i) disable iff (!rst_n_i) (is_exit && sp == PTR_RESET));
	cov_indirect: cover property (@(posedge clk_i) disable iff (!rst_n_i) (op_i == SCS_OP_CALLI) ##1 (op_i == SCS_OP_RET));
	cov_pulse_op: cover property (@(posedge clk_i) disable iff (!rst_n_i) (int_rst && op_i != SCS_OP_NONE));
endmodule

`default_nettype wire

// File: scs_call_stack_bench.sv
// self-checking bench for the subroutine call stack
`timescale 1ns/100ps
`default_nettype none
module scs_call_stack_bench;
	import scs_pkg::*;
	logic              clk_i = 1'b0;
	logic              rst_n_i = 1'b0;
	scs_op_t           op_i = SCS_OP_NONE;
	scs_cond_t         cond_i = SCS_COND_Z;
	logic              zero_flag_i = 1'b0;
	logic              carry_flag_i = 1'b0;
	logic [ADDR_W-1:0] target_i = 12'h000;
	logic [DATA_W-1:0] high_target_register_i = 8'h00;
	logic [DATA_W-1:0] low_target_register_i = 8'h00;
	logic [ADDR_W-1:0] irq_vector_i = 12'h7f0;
	logic [ADDR_W-1:0] pc_o;
	logic [PTR_W-1:0]  depth_o;
	logic              internal_reset_o;
	int                err_total = 0;
	int                samples_checked = 0;

	always #12.5 clk_i = ~clk_i;

	scs_call_stack u_scs_call_stack (
		.clk_i                  (clk_i),
		.rst_n_i                (rst_n_i),
		.op_i                   (op_i),
		.cond_i                 (cond_i),
		.zero_flag_i            (zero_flag_i),
		.carry_flag_i           (carry_flag_i),
		.target_i               (target_i),
		.high_target_register_i (high_target_register_i),
		.low_target_register_i  (low_target_register_i),
		.irq_vector_i           (irq_vector_i),
		.pc_o                   (pc_o),
		.depth_o                (depth_o),
		.internal_reset_o       (internal_reset_o)
	);

	//==============================================================
	// shared tasks
	//==============================================================
	task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic state(input logic [11:0] pc, input logic [4:0] d, input logic r);
		chk("pc", pc_o, pc);
		chk("depth", {7'h00, depth_o}, {7'h00, d});
		chk("pulse", {11'h000, internal_reset_o}, {11'h000, r});
	endtask

	// one op per two cycles, so every result is seen settled at the negedge
	task automatic do_op(input scs_op_t op, input logic [11:0] tgt = 12'h000,
			input scs_cond_t cnd = SCS_COND_Z, input logic f = 1'b0);
		@(posedge clk_i);
		op_i <= op;
		target_i <= tgt;
		cond_i <= cnd;
		zero_flag_i <= f;
		carry_flag_i <= f;
		@(posedge clk_i);
		op_i <= SCS_OP_NONE;
		@(negedge clk_i);
	endtask

	//==============================================================
	// scenarios
	//==============================================================
	task automatic t_nest();
		repeat (3) do_op(SCS_OP_STEP);
		do_op(SCS_OP_CALL, 12'h4a7);
		state(12'h4a7, 5'h01, 1'b0);
		@(posedge clk_i);
		high_target_register_i <= 8'hf5;
		low_target_register_i <= 8'h3c;
		do_op(SCS_OP_CALLI);
		state(12'h53c, 5'h02, 1'b0);
		do_op(SCS_OP_RET);
		state(12'h4a8, 5'h01, 1'b0);
		do_op(SCS_OP_RET);
		state(12'h004, 5'h00, 1'b0);
		$display("test nest done");
	endtask

	task automatic t_cond();
		logic [11:0] p;
		logic        tk;
		scs_cond_t   c;
		for (int i = 0; i < 8; i++) begin
			p = pc_o;
			c = scs_cond_t'(i[1:0]);
			tk = i[2] ^ i[0];
			do_op(SCS_OP_CALLC, 12'h100 + 12'(i), c, i[2]);
			if (tk) begin
				state(12'h100 + 12'(i), 5'h01, 1'b0);
				do_op(SCS_OP_RETC, 12'h000, c, i[2]);
				state(p + 12'h001, 5'h00, 1'b0);
			end else begin
				state(p + 12'h001, 5'h00, 1'b0);
				do_op(SCS_OP_RETC, 12'h000, c, i[2]);
				state(p + 12'h002, 5'h00, 1'b0);
			end
		end
		$display("test cond done");
	endtask

	task automatic t_fault();
		logic [11:0] p;
		p = pc_o;
		do_op(SCS_OP_IRQ);
		state(12'h7f0, 5'h01, 1'b0);
		do_op(SCS_OP_IRET);
		state(p + 12'h001, 5'h00, 1'b0);
		do_op(SCS_OP_IRQ);
		repeat (29) do_op(SCS_OP_CALL, 12'h200);
		state(12'h200, 5'h1e, 1'b0);
		do_op(SCS_OP_CALL, 12'h300);
		state(12'h000, 5'h00, 1'b1);
		do_op(SCS_OP_NONE);
		state(12'h000, 5'h00, 1'b0);
		do_op(SCS_OP_IRET);
		state(12'h000, 5'h00, 1'b1);
		do_op(SCS_OP_STEP);
		do_op(SCS_OP_RET);
		state(12'h000, 5'h00, 1'b1);
		do_op(SCS_OP_RETC, 12'h000, SCS_COND_C, 1'b1);
		state(12'h000, 5'h00, 1'b1);
		do_op(SCS_OP_RETC, 12'h000, SCS_COND_NC, 1'b1);
		state(12'h001, 5'h00, 1'b0);
		$display("test fault done");
	endtask

	// back to back ops, ending with one issued while the fault pulse stands
	task automatic t_b2b();
		logic [11:0] p;
		p = pc_o;
		@(posedge clk_i);
		high_target_register_i <= 8'ha6;
		low_target_register_i <= 8'h15;
		op_i <= SCS_OP_CALL;
		target_i <= 12'h2c0;
		@(posedge clk_i);
		target_i <= 12'h2d0;
		@(posedge clk_i);
		op_i <= SCS_OP_RET;
		@(negedge clk_i);
		state(12'h2d0, 5'h02, 1'b0);
		@(posedge clk_i);
		op_i <= SCS_OP_CALLI;
		@(posedge clk_i);
		op_i <= SCS_OP_RET;
		@(negedge clk_i);
		state(12'h615, 5'h02, 1'b0);
		@(posedge clk_i);
		@(negedge clk_i);
		state(12'h2c2, 5'h01, 1'b0);
		@(posedge clk_i);
		@(negedge clk_i);
		state(p + 12'h001, 5'h00, 1'b0);
		@(posedge clk_i);
		op_i <= SCS_OP_STEP;
		@(negedge clk_i);
		state(12'h000, 5'h00, 1'b1);
		@(posedge clk_i);
		op_i <= SCS_OP_NONE;
		@(negedge clk_i);
		state(12'h000, 5'h00, 1'b0);
		$display("test b2b done");
	endtask

	// a mid-run reset must clear a live stack like the power-on one
	task automatic t_reset();
		do_op(SCS_OP_CALL, 12'h3a5);
		state(12'h3a5, 5'h01, 1'b0);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		op_i <= SCS_OP_STEP;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		op_i <= SCS_OP_NONE;
		@(negedge clk_i);
		state(12'h000, 5'h00, 1'b0);
		do_op(SCS_OP_RET);
		state(12'h000, 5'h00, 1'b1);
		$display("test reset done");
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(negedge clk_i);
		state(12'h000, 5'h00, 1'b0);
		t_nest();
		t_cond();
		t_b2b();
		t_fault();
		t_reset();
		conclude();
	end

	// about 150 cycles are needed; the margin covers a stalled op
	initial begin
		repeat (3000) @(posedge clk_i);
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
